// [inc/oag_ea_if.sv]
`default_nettype none
interface oag_ea_if;
  import oag_pkg::*;
  logic [3:0]   mode;
  logic [1:0]   size;
  logic [31:0]  reg_val;
  logic [31:0]  idx_val;
  logic [31:0]  gbr_val;
  logic [31:0]  pc_val;
  logic [7:0]   disp;
  logic [31:0]  ea;
  logic [31:0]  wb_val;
  logic         wb_en;
  logic         mem_en;
  modport calc (input mode, size, reg_val, idx_val, gbr_val, pc_val, disp,
                output ea, wb_val, wb_en, mem_en);
  modport user (output mode, size, reg_val, idx_val, gbr_val, pc_val, disp,
                input ea, wb_val, wb_en, mem_en);
endinterface
`default_nettype wire

// [inc/oag_pkg.sv]
`default_nettype none
package oag_pkg;
  // operand addressing modes
  typedef enum logic [3:0] {
    OAG_MODE_DIRECT   = 4'h0,
    OAG_MODE_INDIRECT = 4'h1,
    OAG_MODE_POSTINC  = 4'h2,
    OAG_MODE_PREDEC   = 4'h3,
    OAG_MODE_DISP4    = 4'h4,
    OAG_MODE_INDEXED  = 4'h5,
    OAG_MODE_GBR_DISP = 4'h6,
    OAG_MODE_PC_DISP  = 4'h7,
    OAG_MODE_IMM8     = 4'h8,
    OAG_MODE_LITERAL  = 4'h9
  } oag_mode_type;

  // access sizes
  typedef enum logic [1:0] {
    OAG_SIZE_BYTE = 2'h0,
    OAG_SIZE_WORD = 2'h1,
    OAG_SIZE_LONG = 2'h2
  } oag_size_type;

  // flag operations
  typedef enum logic [2:0] {
    OAG_FLAG_NONE   = 3'h0,
    OAG_FLAG_COMPARE_GREATER_EQUAL = 3'h1,
    OAG_FLAG_COMPARE_EQUAL = 3'h2,
    OAG_FLAG_BR_SET = 3'h3,
    OAG_FLAG_BR_CLR = 3'h4
  } oag_flag_op_type;

  // pipeline states, gray along the usual path
  typedef enum logic [1:0] {
    OAG_ST_IDLE = 2'b00,
    OAG_ST_BUSY = 2'b01
  } oag_state_type;

  localparam int          OAG_XLEN       = 32;
  localparam logic        OAG_FLAG_RESET = 1'b0;
  localparam logic [31:0] OAG_ADDR_RESET = 32'h0000_0000;
  localparam int          OAG_LAT_CYCLES = 1;
endpackage
`default_nettype wire

// [logic/oag_ea_calc.sv]
`default_nettype none
module oag_ea_calc
  import oag_pkg::*;
(
  oag_ea_if.calc ea_bus
);
  // access size in bytes: 1, 2 or 4
  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    case (sz)
      OAG_SIZE_WORD: size_bytes = 32'h0000_0002;
      OAG_SIZE_LONG: size_bytes = 32'h0000_0004;
      default:       size_bytes = 32'h0000_0001;
    endcase
  endfunction

  // zero-extended displacement scaled by the access size
  function automatic logic [31:0] scale_disp(input logic [31:0] d,
                                             input logic [1:0]  sz);
    case (sz)
      OAG_SIZE_WORD: scale_disp = {d[30:0], 1'b0};
      OAG_SIZE_LONG: scale_disp = {d[29:0], 2'b00};
      default:       scale_disp = d;
    endcase
  endfunction

  // address arithmetic, 32-bit wrap-around
  always_comb
  begin
    ea_bus.ea     = 32'h0000_0000;
    ea_bus.wb_val = ea_bus.reg_val;
    ea_bus.wb_en  = 1'b0;
    ea_bus.mem_en = 1'b1;
    case (ea_bus.mode)
      OAG_MODE_DIRECT:
      begin
        ea_bus.mem_en = 1'b0;
      end
      OAG_MODE_INDIRECT: ea_bus.ea = ea_bus.reg_val;
      OAG_MODE_POSTINC:
      begin
        ea_bus.ea     = ea_bus.reg_val;
        ea_bus.wb_val = ea_bus.reg_val + size_bytes(ea_bus.size);
        ea_bus.wb_en  = 1'b1;
      end
      OAG_MODE_PREDEC:
      begin
        ea_bus.wb_val = ea_bus.reg_val - size_bytes(ea_bus.size);
        ea_bus.ea     = ea_bus.wb_val;
        ea_bus.wb_en  = 1'b1;
      end
      OAG_MODE_DISP4:
        ea_bus.ea = ea_bus.reg_val
          + scale_disp({28'h0, ea_bus.disp[3:0]}, ea_bus.size);
      OAG_MODE_INDEXED:
        ea_bus.ea = ea_bus.reg_val + ea_bus.idx_val;
      OAG_MODE_GBR_DISP:
        ea_bus.ea = ea_bus.gbr_val
          + scale_disp({24'h0, ea_bus.disp}, ea_bus.size);
      OAG_MODE_PC_DISP, OAG_MODE_LITERAL:
        ea_bus.ea = ea_bus.pc_val
          + {{23{ea_bus.disp[7]}}, ea_bus.disp, 1'b0};
      OAG_MODE_IMM8: ea_bus.mem_en = 1'b0;
      default:       ea_bus.mem_en = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [logic/oag_top.sv]
// Operation
// - compare-ge sets flag if first >= second; branches test the flag
// - register add leaves the condition flag unchanged
// - compare-equal immediate sets flag on equality, clears it otherwise
// - 8-bit immediate comes straight from the instruction word
// - wider immediates are loaded from a pc-relative literal table
// - direct mode uses register contents, no memory address
// - indirect mode address is register contents, register unchanged
// - post-increment uses register, then adds 1, 2 or 4
// - pre-decrement subtracts 1, 2 or 4 first, writes back, uses it
// - register plus zero-extended 4-bit displacement scaled by size
// - indexed address is register plus register zero
// - global base plus zero-extended 8-bit displacement scaled by size
// - pc plus sign-extended 8-bit displacement doubled
`default_nettype none
module oag_top
  import oag_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_valid,
  input  wire oag_pkg::oag_mode_type i_mode,
  input  wire oag_pkg::oag_size_type i_size,
  input  wire oag_pkg::oag_flag_op_type i_flag_op,
  input  wire logic [31:0]           i_selected_general_register,
  input  wire logic [31:0]           i_second_register,
  input  wire logic [31:0]           i_index_register_zero,
  input  wire logic [31:0]           i_global_base_pointer,
  input  wire logic [31:0]           i_pc,
  input  wire logic [7:0]            i_field8,
  output logic                       o_valid,
  output logic [31:0]                o_addr,
  output logic                       o_mem_en,
  output logic [31:0]                o_operand,
  output logic                       o_wb_en,
  output logic [31:0]                o_wb_val,
  output logic                       o_flag,
  output logic                       o_branch_taken
);
  ////////////////////////////////////////////////////////////////////////////
  oag_ea_if ea_bus ();

  oag_ea_calc u_calc (
    .ea_bus (ea_bus.calc)
  );

  // feed the address unit
  assign ea_bus.mode    = i_mode;
  assign ea_bus.size    = i_size;
  assign ea_bus.reg_val = i_selected_general_register;
  assign ea_bus.idx_val = i_index_register_zero;
  assign ea_bus.gbr_val = i_global_base_pointer;
  assign ea_bus.pc_val  = i_pc;
  assign ea_bus.disp    = i_field8;

  ////////////////////////////////////////////////////////////////////////////
  logic        valid_ff, nxt_valid;
  logic [31:0] addr_ff, nxt_addr;
  logic        mem_en_ff, nxt_mem_en;
  logic [31:0] operand_ff, nxt_operand;
  logic        wb_en_ff, nxt_wb_en;
  logic [31:0] wb_val_ff, nxt_wb_val;
  logic        flag_ff, nxt_flag;
  logic        br_ff, nxt_br;

  // next values for address outputs and condition flag
  always_comb
  begin
    nxt_valid   = i_valid;
    nxt_addr    = addr_ff;
    nxt_mem_en  = 1'b0;
    nxt_operand = operand_ff;
    nxt_wb_en   = 1'b0;
    nxt_wb_val  = wb_val_ff;
    nxt_flag    = flag_ff;
    nxt_br      = 1'b0;
    if (i_valid)
    begin
      nxt_addr   = ea_bus.ea;
      nxt_mem_en = ea_bus.mem_en;
      nxt_wb_en  = ea_bus.wb_en;
      nxt_wb_val = ea_bus.wb_val;
      if (i_mode == OAG_MODE_IMM8)
        nxt_operand = {{24{i_field8[7]}}, i_field8};
      else
        nxt_operand = i_selected_general_register;
      case (i_flag_op)
        OAG_FLAG_COMPARE_GREATER_EQUAL:
          nxt_flag = ($signed(i_selected_general_register)
                      >= $signed(i_second_register));
        OAG_FLAG_COMPARE_EQUAL:
          nxt_flag = (i_selected_general_register
                      == {{24{i_field8[7]}}, i_field8});
        OAG_FLAG_BR_SET: nxt_br = flag_ff;
        OAG_FLAG_BR_CLR: nxt_br = ~flag_ff;
        default:         nxt_flag = flag_ff;
      endcase
    end
  end

  // registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      valid_ff   <= 1'b0;
      addr_ff    <= OAG_ADDR_RESET;
      mem_en_ff  <= 1'b0;
      operand_ff <= OAG_ADDR_RESET;
      wb_en_ff   <= 1'b0;
      wb_val_ff  <= OAG_ADDR_RESET;
      flag_ff    <= OAG_FLAG_RESET;
      br_ff      <= 1'b0;
    end
    else
    begin
      valid_ff   <= nxt_valid;
      addr_ff    <= nxt_addr;
      mem_en_ff  <= nxt_mem_en;
      operand_ff <= nxt_operand;
      wb_en_ff   <= nxt_wb_en;
      wb_val_ff  <= nxt_wb_val;
      flag_ff    <= nxt_flag;
      br_ff      <= nxt_br;
    end
  end

  assign o_valid        = valid_ff;
  assign o_addr         = addr_ff;
  assign o_mem_en       = mem_en_ff;
  assign o_operand      = operand_ff;
  assign o_wb_en        = wb_en_ff;
  assign o_wb_val       = wb_val_ff;
  assign o_flag         = flag_ff;
  assign o_branch_taken = br_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // plain instructions keep the flag
  a_add_keeps_flag: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_flag_op == OAG_FLAG_NONE) |=> $stable(o_flag))
    else $error("flag changed without compare");

  // branches read the flag but never write it
  a_branch_keeps_flag: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_flag_op == OAG_FLAG_BR_SET || i_flag_op == OAG_FLAG_BR_CLR)
      |=> $stable(o_flag))
    else $error("branch changed the flag");

  // signed greater-or-equal compare
  a_compare_greater_equal_flag: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_flag_op == OAG_FLAG_COMPARE_GREATER_EQUAL) |=>
      o_flag == ($signed($past(i_selected_general_register))
                 >= $signed($past(i_second_register))))
    else $error("compare ge flag wrong");

  // compare against immediate zero
  a_compare_equal_flag: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_flag_op == OAG_FLAG_COMPARE_EQUAL && i_field8 == 8'h00) |=>
      o_flag == ($past(i_selected_general_register) == 32'h0000_0000))
    else $error("compare eq flag wrong");

  // branch when the flag is set
  a_branch_set: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_flag_op == OAG_FLAG_BR_SET) |=>
      o_branch_taken == $past(o_flag))
    else $error("branch on set wrong");

  // branch when the flag is clear
  a_branch_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_flag_op == OAG_FLAG_BR_CLR) |=>
      o_branch_taken == !$past(o_flag))
    else $error("branch on clear wrong");

  // indirect: address is the register, no write-back
  a_indirect_addr: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_INDIRECT) |=>
      o_addr == $past(i_selected_general_register) && !o_wb_en)
    else $error("indirect address wrong");

  // post-increment by four
  a_postinc_long: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_POSTINC && i_size == OAG_SIZE_LONG) |=>
      o_wb_val == o_addr + 32'h0000_0004 && o_wb_en)
    else $error("post increment wrong");

  // post-increment by one, address is the old register
  a_postinc_byte: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_POSTINC && i_size == OAG_SIZE_BYTE) |=>
      o_addr == $past(i_selected_general_register)
      && o_wb_val == o_addr + 32'h0000_0001 && o_wb_en)
    else $error("post increment byte wrong");

  // pre-decrement by two
  a_predec_word: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_PREDEC && i_size == OAG_SIZE_WORD) |=>
      o_addr == $past(i_selected_general_register) - 32'h0000_0002
      && o_wb_val == o_addr)
    else $error("pre decrement wrong");

  // pre-decrement by four, written back
  a_predec_long: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_PREDEC && i_size == OAG_SIZE_LONG) |=>
      o_addr == $past(i_selected_general_register) - 32'h0000_0004
      && o_wb_val == o_addr && o_wb_en)
    else $error("pre decrement long wrong");

  // short displacement, longword scaling
  a_disp4_long: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_DISP4 && i_size == OAG_SIZE_LONG) |=>
      o_addr == $past(i_selected_general_register)
                + {26'h0, $past(i_field8[3:0]), 2'b00})
    else $error("short displacement wrong");

  // register plus register zero
  a_indexed_addr: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_INDEXED) |=>
      o_addr == $past(i_selected_general_register)
                + $past(i_index_register_zero))
    else $error("indexed address wrong");

  // global base displacement, word scaling
  a_gbr_word: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_GBR_DISP && i_size == OAG_SIZE_WORD) |=>
      o_addr == $past(i_global_base_pointer)
                + {23'h0, $past(i_field8), 1'b0})
    else $error("global base displacement wrong");

  // pc relative with a zero field lands on the pc itself
  a_pc_zero_disp: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_PC_DISP && i_field8 == 8'h00) |=>
      o_addr == $past(i_pc) && o_mem_en)
    else $error("pc relative address wrong");

  // literal table load reads memory, no write-back
  a_literal_mem: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_LITERAL) |=> o_mem_en && !o_wb_en)
    else $error("literal load wrong");

  // byte immediate comes from the field, no memory access
  a_imm8_operand: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_IMM8) |=>
      !o_mem_en && o_operand[7:0] == $past(i_field8))
    else $error("byte immediate wrong");

  // direct: operand is the register, no memory
  a_direct_nomem: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_mode == OAG_MODE_DIRECT) |=>
      !o_mem_en && o_operand == $past(i_selected_general_register))
    else $error("direct mode touched memory");

  // pulses only follow an accepted instruction
  a_idle_pulses: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_valid |=> !o_valid && !o_mem_en && !o_wb_en && !o_branch_taken)
    else $error("pulse without instruction");
endmodule
`default_nettype wire

// [tb/test_oag_top.sv]
`default_nettype none
module test_oag_top;
  timeunit 1ns;
  timeprecision 1ns;
  import oag_pkg::*;

  logic            i_ref_clk = 1'b0;
  logic            i_rst = 1'b1;
  logic            i_valid = 1'b0;
  oag_mode_type    i_mode = OAG_MODE_DIRECT;
  oag_size_type    i_size = OAG_SIZE_BYTE;
  oag_flag_op_type i_flag_op = OAG_FLAG_NONE;
  logic [31:0]     rn = 32'h0;
  logic [31:0]     r2 = 32'h0;
  logic [31:0]     r0 = 32'h10;
  logic [31:0]     global_base_pointer = 32'h1000;
  logic [31:0]     pc = 32'h1000;
  logic [7:0]      f8 = 8'h0;
  logic            o_valid, o_mem_en, o_wb_en, o_flag, o_branch_taken;
  logic [31:0]     o_addr, o_operand, o_wb_val;
  int              bad_count = 0;
  int              compares = 0;
  int              cycles = 0;

  oag_top DUT (
    .i_ref_clk                   (i_ref_clk),
    .i_rst                       (i_rst),
    .i_valid                     (i_valid),
    .i_mode                      (i_mode),
    .i_size                      (i_size),
    .i_flag_op                   (i_flag_op),
    .i_selected_general_register (rn),
    .i_second_register           (r2),
    .i_index_register_zero       (r0),
    .i_global_base_pointer       (global_base_pointer),
    .i_pc                        (pc),
    .i_field8                    (f8),
    .o_valid                     (o_valid),
    .o_addr                      (o_addr),
    .o_mem_en                    (o_mem_en),
    .o_operand                   (o_operand),
    .o_wb_en                     (o_wb_en),
    .o_wb_val                    (o_wb_val),
    .o_flag                      (o_flag),
    .o_branch_taken              (o_branch_taken)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  always #50 i_ref_clk = ~i_ref_clk;

  // hang guard: the tests need well under a hundred cycles
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    if (seen !== exp)
      bad_count++;
  endtask

  // one instruction, outputs settled on return
  task automatic op(input oag_mode_type m, input oag_size_type s,
                    input oag_flag_op_type f, input logic [31:0] a,
                    input logic [7:0] d);
    @(negedge i_ref_clk);
    i_mode = m;
    i_size = s;
    i_flag_op = f;
    rn = a;
    f8 = d;
    i_valid = 1'b1;
    @(negedge i_ref_clk);
    i_valid = 1'b0;
  endtask

  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // every addressing mode, every size for post-inc, pre-dec, disp4 and gbr, with boundary fields
  task automatic t_modes;
    logic [31:0] n;
    for (int s = 0; s < 3; s++)
    begin
      n = 32'h1 << s;
      op(OAG_MODE_POSTINC, oag_size_type'(s), OAG_FLAG_NONE, 32'h100, 8'h0);
      chk(o_addr, 32'h100);
      chk(o_wb_val, 32'h100 + n);
      chk({30'h0, o_wb_en, o_mem_en}, 32'h3);
      op(OAG_MODE_PREDEC, oag_size_type'(s), OAG_FLAG_NONE, 32'h100, 8'h0);
      chk(o_addr, 32'h100 - n);
      chk(o_wb_val, 32'h100 - n);
      chk({31'h0, o_wb_en}, 32'h1);
      op(OAG_MODE_DISP4, oag_size_type'(s), OAG_FLAG_NONE, 32'h200, 8'hff);
      chk(o_addr, 32'h200 + 32'hf * n);
      op(OAG_MODE_GBR_DISP, oag_size_type'(s), OAG_FLAG_NONE, 32'h0, 8'hff);
      chk(o_addr, 32'h1000 + 32'hff * n);
    end
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_NONE, 32'h1234, 8'h0);
    chk(o_operand, 32'h1234);
    chk({30'h0, o_wb_en, o_mem_en}, 32'h0);
    op(OAG_MODE_INDIRECT, OAG_SIZE_LONG, OAG_FLAG_NONE, 32'h5678, 8'h0);
    chk(o_addr, 32'h5678);
    chk({30'h0, o_wb_en, o_mem_en}, 32'h1);
    op(OAG_MODE_INDEXED, OAG_SIZE_WORD, OAG_FLAG_NONE, 32'h20, 8'h0);
    chk(o_addr, 32'h30);
    op(OAG_MODE_PC_DISP, OAG_SIZE_WORD, OAG_FLAG_NONE, 32'h0, 8'h80);
    chk(o_addr, 32'hf00);
    op(OAG_MODE_IMM8, OAG_SIZE_BYTE, OAG_FLAG_NONE, 32'h0, 8'h80);
    chk(o_operand, 32'hffffff80);
    chk({31'h0, o_mem_en}, 32'h0);
    op(OAG_MODE_LITERAL, OAG_SIZE_LONG, OAG_FLAG_NONE, 32'h0, 8'h02);
    chk(o_addr, 32'h1004);
    chk({31'h0, o_mem_en}, 32'h1);
    op(OAG_MODE_POSTINC, OAG_SIZE_LONG, OAG_FLAG_NONE, 32'hfffffffe, 8'h0);
    chk(o_wb_val, 32'h2);
    op(OAG_MODE_PREDEC, OAG_SIZE_BYTE, OAG_FLAG_NONE, 32'h0, 8'h0);
    chk(o_addr, 32'hffffffff);
    $display("modes test done");
  endtask

  // compares, branches, and instructions that must not touch the flag
  task automatic t_flags;
    chk({31'h0, o_flag}, 32'h0);
    r2 = 32'h3;
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_COMPARE_GREATER_EQUAL, 32'h5, 8'h0);
    chk({31'h0, o_flag}, 32'h1);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_BR_SET, 32'h0, 8'h0);
    chk({31'h0, o_branch_taken}, 32'h1);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_BR_CLR, 32'h0, 8'h0);
    chk({31'h0, o_branch_taken}, 32'h0);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_NONE, 32'h0, 8'h0);
    chk({30'h0, o_valid, o_flag}, 32'h3);
    @(negedge i_ref_clk);
    chk({30'h0, o_valid, o_flag}, 32'h1);
    r2 = 32'h1;
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_COMPARE_GREATER_EQUAL, 32'hffffffff, 8'h0);
    chk({31'h0, o_flag}, 32'h0);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_BR_CLR, 32'h0, 8'h0);
    chk({31'h0, o_branch_taken}, 32'h1);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_COMPARE_EQUAL, 32'h0, 8'h0);
    chk({31'h0, o_flag}, 32'h1);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_COMPARE_EQUAL, 32'h1, 8'h0);
    chk({31'h0, o_flag}, 32'h0);
    op(OAG_MODE_DIRECT, OAG_SIZE_LONG, OAG_FLAG_COMPARE_EQUAL, 32'hffffffff, 8'hff);
    chk({31'h0, o_flag}, 32'h1);
    $display("flags test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset for two cycles, then run the tests
  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    t_flags();
    t_modes();
    test_done();
  end
endmodule
`default_nettype wire
